// ===== src/tvfl_pkg.sv
/*
  Constants, types and the linear-format decoder shared by the threshold
  bank and its fault response engines.
  Assumes a 10 MHz core clock and decoded PMBus command transactions.
*/
`default_nettype none
package tvfl_pkg;
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CMD_UT_WARN = 8'h52;
  localparam logic [7:0] CMD_UT_FAULT = 8'h53;
  localparam logic [7:0] CMD_UT_ACTION = 8'h54;
  localparam logic [7:0] CMD_VIN_OV = 8'h55;
  localparam logic [7:0] CMD_VIN_ACTION = 8'h56;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;
  localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_OT_WARN = 16'heb70;
  localparam logic [15:0] RST_UT_WARN = 16'he580;
  localparam logic [15:0] RST_UT_FAULT = 16'he490;
  localparam logic [15:0] RST_VIN_OV = 16'hd3a0;
  localparam logic [7:0] RST_ACTION = 8'h80;
  // ----------------------------------------
  // Response byte fields and codes
  // ----------------------------------------
  localparam int BEHAV_HI = 7;
  localparam int BEHAV_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int TIME_HI = 2;
  localparam int TIME_LO = 0;
  localparam logic [1:0] BEH_IGNORE = 2'h0;
  localparam logic [1:0] BEH_DELAY = 2'h1;
  localparam logic [1:0] BEH_DISABLE = 2'h2;
  localparam logic [1:0] BEH_HOLD = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int SB_OFF = 6;
  localparam int SB_TEMP = 2;
  localparam int SB_OTHER = 0;
  localparam int SW_INPUT = 13;
  localparam int ST_OT_WARN = 6;
  localparam int ST_UT_WARN = 5;
  localparam int ST_UT_FAULT = 4;
  localparam int SI_VIN_OV = 7;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int UNIT_TIME_NS = 1000000;
  localparam int UNIT_CYCLES = UNIT_TIME_NS / CLK_PERIOD_NS;
  localparam int FIX_W = 48;
  localparam int EXP_BIAS = 16;

  typedef enum logic [2:0] {st_run, st_delay, st_off, st_wait, st_hold} tvfl_resp_e;

  // Linear word to fixed point, 16 fraction bits, so words compare exactly
  function automatic logic signed [FIX_W-1:0] l11_fix(input logic [15:0] w);
    logic signed [4:0] e;
    logic signed [10:0] m;
    logic [5:0] sh;
    e = w[15:11];
    m = w[10:0];
    sh = 6'(int'(e) + EXP_BIAS);
    l11_fix = FIX_W'(m) <<< sh;
  endfunction
endpackage
`default_nettype wire

// ===== src/tvfl_response.sv
/*
  Fault response engine: delay, disable, retry and hold per response byte.
  Assumes fault_in is a level from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module tvfl_response #(
  parameter int UNIT_CYCLES = tvfl_pkg::UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic fault_in,
  input wire logic [7:0] action_in,
  input wire logic clear_in,
  // Result
  output logic enable_out
);
  tvfl_pkg::tvfl_resp_e state, next_state;
  logic [2:0] left, next_left;
  logic [2:0] used, next_used;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic next_enable;
  logic tick;
  logic [1:0] beh;
  logic [2:0] retry;
  logic [2:0] tim;

  assign beh = action_in[tvfl_pkg::BEHAV_HI:tvfl_pkg::BEHAV_LO];
  assign retry = action_in[tvfl_pkg::RETRY_HI:tvfl_pkg::RETRY_LO];
  assign tim = action_in[tvfl_pkg::TIME_HI:tvfl_pkg::TIME_LO];
  assign tick = (tick_cnt == 32'(UNIT_CYCLES - 1));

  always_comb
  begin
    next_state = state;
    next_left = left;
    next_used = used;
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
    if (clear_in)
    begin
      next_used = 3'h0;
    end
    case (state)
      tvfl_pkg::st_run:
        if (fault_in)
        begin
          case (beh)
            tvfl_pkg::BEH_DELAY:
            begin
              next_left = tim;
              next_state = tvfl_pkg::st_delay;
            end
            tvfl_pkg::BEH_DISABLE: next_state = tvfl_pkg::st_off;
            tvfl_pkg::BEH_HOLD: next_state = tvfl_pkg::st_hold;
            default: next_state = tvfl_pkg::st_run;
          endcase
        end
      tvfl_pkg::st_delay:
        if (left == 3'h0)
        begin
          next_state = tvfl_pkg::st_off;
        end
        else if (tick)
        begin
          next_left = left - 3'h1;
        end
      tvfl_pkg::st_off:
        // No retry stays off until reset; counted retries stop when used up
        if (retry != tvfl_pkg::RETRY_NONE && (retry == tvfl_pkg::RETRY_FOREVER || used < retry))
        begin
          next_left = tim;
          next_state = tvfl_pkg::st_wait;
        end
      tvfl_pkg::st_wait:
        if (left == 3'h0)
        begin
          // Restart blind; a lasting fault trips again from run
          next_state = tvfl_pkg::st_run;
          if (retry != tvfl_pkg::RETRY_FOREVER)
          begin
            next_used = used + 3'h1;
          end
        end
        else if (tick)
        begin
          next_left = left - 3'h1;
        end
      tvfl_pkg::st_hold:
        if (!fault_in)
        begin
          next_state = tvfl_pkg::st_run;
        end
      default: next_state = tvfl_pkg::st_off;
    endcase
    // Output stays on while the response delay runs
    next_enable = (next_state == tvfl_pkg::st_run) || (next_state == tvfl_pkg::st_delay);
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= tvfl_pkg::st_run;
      left <= 3'h0;
      used <= 3'h0;
      tick_cnt <= 32'h0;
      enable_out <= 1'b1;
    end
    else
    begin
      state <= next_state;
      left <= next_left;
      used <= next_used;
      tick_cnt <= next_tick_cnt;
      enable_out <= next_enable;
    end
  end

  ignore_fault_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == tvfl_pkg::st_run && beh == tvfl_pkg::BEH_IGNORE |=> enable_out)
    else $error("ignore response dropped the output");
  disable_now_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == tvfl_pkg::st_run && fault_in && beh == tvfl_pkg::BEH_DISABLE |=> !enable_out && state == tvfl_pkg::st_off)
    else $error("disable response did not disable at once");
  hold_release_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == tvfl_pkg::st_hold |=> enable_out == !$past(fault_in))
    else $error("hold response wrong for fault level");
  no_retry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == tvfl_pkg::st_off && retry == tvfl_pkg::RETRY_NONE |=> state == tvfl_pkg::st_off && !enable_out)
    else $error("no-retry setting restarted");
  delay_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == tvfl_pkg::st_run && fault_in && beh == tvfl_pkg::BEH_DELAY && tim == 3'h0
    |=> enable_out ##1 !enable_out)
    else $error("zero delay response not taken in two cycles");
  retry_seen_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    state == tvfl_pkg::st_wait ##1 state == tvfl_pkg::st_run);
  hold_seen_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    state == tvfl_pkg::st_hold ##1 state == tvfl_pkg::st_run);
endmodule
`default_nettype wire

// ===== src/tvfl_limits.sv
/*
  Temperature and input-voltage threshold bank with status, alert and
  fault responses. Assumes a PMBus front end that hands over decoded
  command codes with write and read strobes, and measurements as linear
  words synchronous to clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Temperature above over-temp warning sets summary and warning bits, alerts.
// - Over-temp warning word is read/write, resets to eb70 (110 C).
// - Temperature below under-temp warning sets summary and warning bits, alerts.
// - Under-temp warning word resets to e580 (-40 C).
// - Under-temp fault declared at its threshold, cleared only above warning.
// - Under-temp fault word resets to e490 (-55 C).
// - Every threshold is a read/write two-byte linear word.
// - Response registers are read/write bytes; under-temp one resets to 80.
// - Behaviour 00 ignores the fault but still records status.
// - Behaviour 01 waits the time field, disables, then retries.
// - Behaviour 10 disables at once, then retries per retry field.
// - Behaviour 11 holds output off while fault persists, then re-enables.
// - Fault bits stay set until the clear-faults command.
// - Retry 000 keeps output disabled until device restart.
// - Retry 001 to 110 restarts that many times, spaced by time field.
// - Retry 111 restarts endlessly without checking the fault.
// - Time field gives both retry spacing and response delay.
// - Input overvoltage threshold resets to d3a0 (14.5 V).
// - Input overvoltage response uses same encoding, resets to 80.
// - Status byte bit 2 reports any temperature fault or warning.
module tvfl_limits #(
  parameter int UT_UNIT_CYCLES = tvfl_pkg::UNIT_CYCLES,
  parameter int VIN_UNIT_CYCLES = tvfl_pkg::UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Decoded command port
  input wire logic [7:0] cmd_code_in,
  input wire logic cmd_wr_in,
  input wire logic cmd_rd_in,
  input wire logic [15:0] cmd_wdata_in,
  output logic [15:0] cmd_rdata_out,
  // Measurements, linear format
  input wire logic [15:0] temp_in,
  input wire logic [15:0] vin_in,
  // Alert and power stage
  output logic alert_n_out,
  output logic power_enable_out
);
  // ----------------------------------------
  // Threshold and response registers
  // ----------------------------------------
  logic [15:0] ot_warn, next_ot_warn;
  logic [15:0] ut_warn, next_ut_warn;
  logic [15:0] ut_fault, next_ut_fault;
  logic [7:0] ut_action, next_ut_action;
  logic [15:0] vin_ov, next_vin_ov;
  logic [7:0] vin_action, next_vin_action;
  logic [15:0] next_rdata;
  logic wr_ok;

  assign wr_ok = cmd_wr_in;

  always_comb
  begin
    next_ot_warn = ot_warn;
    next_ut_warn = ut_warn;
    next_ut_fault = ut_fault;
    next_ut_action = ut_action;
    next_vin_ov = vin_ov;
    next_vin_action = vin_action;
    if (wr_ok)
    begin
      if (cmd_code_in == tvfl_pkg::CMD_OT_WARN)
      begin
        next_ot_warn = cmd_wdata_in;
      end
      else if (cmd_code_in == tvfl_pkg::CMD_UT_WARN)
      begin
        next_ut_warn = cmd_wdata_in;
      end
      else if (cmd_code_in == tvfl_pkg::CMD_UT_FAULT)
      begin
        next_ut_fault = cmd_wdata_in;
      end
      else if (cmd_code_in == tvfl_pkg::CMD_UT_ACTION)
      begin
        next_ut_action = cmd_wdata_in[7:0];
      end
      else if (cmd_code_in == tvfl_pkg::CMD_VIN_OV)
      begin
        next_vin_ov = cmd_wdata_in;
      end
      else if (cmd_code_in == tvfl_pkg::CMD_VIN_ACTION)
      begin
        next_vin_action = cmd_wdata_in[7:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ot_warn <= tvfl_pkg::RST_OT_WARN;
      ut_warn <= tvfl_pkg::RST_UT_WARN;
      ut_fault <= tvfl_pkg::RST_UT_FAULT;
      ut_action <= tvfl_pkg::RST_ACTION;
      vin_ov <= tvfl_pkg::RST_VIN_OV;
      vin_action <= tvfl_pkg::RST_ACTION;
    end
    else
    begin
      ot_warn <= next_ot_warn;
      ut_warn <= next_ut_warn;
      ut_fault <= next_ut_fault;
      ut_action <= next_ut_action;
      vin_ov <= next_vin_ov;
      vin_action <= next_vin_action;
    end
  end

  // ----------------------------------------
  // Comparisons
  // ----------------------------------------
  // Range limits are not enforced; any word is stored and compared as is
  logic signed [tvfl_pkg::FIX_W-1:0] temp_fix, vin_fix;
  logic above_ot, below_ut, at_ut_fault, above_ut_warn, above_vin;

  always_comb
  begin
    temp_fix = tvfl_pkg::l11_fix(temp_in);
    vin_fix = tvfl_pkg::l11_fix(vin_in);
    above_ot = temp_fix > tvfl_pkg::l11_fix(ot_warn);
    below_ut = temp_fix < tvfl_pkg::l11_fix(ut_warn);
    above_ut_warn = temp_fix > tvfl_pkg::l11_fix(ut_warn);
    at_ut_fault = temp_fix <= tvfl_pkg::l11_fix(ut_fault);
    above_vin = vin_fix > tvfl_pkg::l11_fix(vin_ov);
  end

  // ----------------------------------------
  // Status, alert and output enable
  // ----------------------------------------
  logic clear_faults;
  logic ut_cond, next_ut_cond;
  logic ot_warn_flag, next_ot_warn_flag;
  logic ut_warn_flag, next_ut_warn_flag;
  logic ut_fault_flag, next_ut_fault_flag;
  logic vin_ov_flag, next_vin_ov_flag;
  logic next_alert_n;
  logic next_power_en;
  logic ut_enable, vin_enable;
  logic temp_any;
  logic [7:0] status_byte, status_temp, status_input;

  assign clear_faults = cmd_wr_in && cmd_code_in == tvfl_pkg::CMD_CLEAR_FAULTS;

  always_comb
  begin
    // Hysteresis: set at fault limit, released only above warning limit
    if (ut_cond)
    begin
      next_ut_cond = !above_ut_warn;
    end
    else
    begin
      next_ut_cond = at_ut_fault;
    end
    // Set wins over clear so an event in the clearing cycle is kept
    next_ot_warn_flag = (ot_warn_flag && !clear_faults) || above_ot;
    next_ut_warn_flag = (ut_warn_flag && !clear_faults) || below_ut;
    next_ut_fault_flag = (ut_fault_flag && !clear_faults) || next_ut_cond;
    next_vin_ov_flag = (vin_ov_flag && !clear_faults) || above_vin;
    next_alert_n = !(next_ot_warn_flag || next_ut_warn_flag || next_ut_fault_flag || next_vin_ov_flag);
    next_power_en = ut_enable && vin_enable;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ut_cond <= 1'b0;
      ot_warn_flag <= 1'b0;
      ut_warn_flag <= 1'b0;
      ut_fault_flag <= 1'b0;
      vin_ov_flag <= 1'b0;
      alert_n_out <= 1'b1;
      power_enable_out <= 1'b1;
    end
    else
    begin
      ut_cond <= next_ut_cond;
      ot_warn_flag <= next_ot_warn_flag;
      ut_warn_flag <= next_ut_warn_flag;
      ut_fault_flag <= next_ut_fault_flag;
      vin_ov_flag <= next_vin_ov_flag;
      alert_n_out <= next_alert_n;
      power_enable_out <= next_power_en;
    end
  end

  tvfl_response #(
    .UNIT_CYCLES(UT_UNIT_CYCLES)
  ) u_ut_resp (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .fault_in(ut_cond),
    .action_in(ut_action),
    .clear_in(clear_faults),
    .enable_out(ut_enable)
  );

  tvfl_response #(
    .UNIT_CYCLES(VIN_UNIT_CYCLES)
  ) u_vin_resp (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .fault_in(above_vin),
    .action_in(vin_action),
    .clear_in(clear_faults),
    .enable_out(vin_enable)
  );

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  always_comb
  begin
    temp_any = ot_warn_flag || ut_warn_flag || ut_fault_flag;
    status_byte = 8'h00;
    status_byte[tvfl_pkg::SB_OFF] = !power_enable_out;
    status_byte[tvfl_pkg::SB_TEMP] = temp_any;
    status_byte[tvfl_pkg::SB_OTHER] = vin_ov_flag;
    status_temp = 8'h00;
    status_temp[tvfl_pkg::ST_OT_WARN] = ot_warn_flag;
    status_temp[tvfl_pkg::ST_UT_WARN] = ut_warn_flag;
    status_temp[tvfl_pkg::ST_UT_FAULT] = ut_fault_flag;
    status_input = 8'h00;
    status_input[tvfl_pkg::SI_VIN_OV] = vin_ov_flag;
    next_rdata = cmd_rdata_out;
    if (cmd_rd_in)
    begin
      next_rdata = 16'h0000;
      if (cmd_code_in == tvfl_pkg::CMD_OT_WARN)
      begin
        next_rdata = ot_warn;
      end
      else if (cmd_code_in == tvfl_pkg::CMD_UT_WARN)
      begin
        next_rdata = ut_warn;
      end
      else if (cmd_code_in == tvfl_pkg::CMD_UT_FAULT)
      begin
        next_rdata = ut_fault;
      end
      else if (cmd_code_in == tvfl_pkg::CMD_UT_ACTION)
      begin
        next_rdata = {8'h00, ut_action};
      end
      else if (cmd_code_in == tvfl_pkg::CMD_VIN_OV)
      begin
        next_rdata = vin_ov;
      end
      else if (cmd_code_in == tvfl_pkg::CMD_VIN_ACTION)
      begin
        next_rdata = {8'h00, vin_action};
      end
      else if (cmd_code_in == tvfl_pkg::CMD_STATUS_BYTE)
      begin
        next_rdata = {8'h00, status_byte};
      end
      else if (cmd_code_in == tvfl_pkg::CMD_STATUS_WORD)
      begin
        next_rdata = {8'h00, status_byte};
        next_rdata[tvfl_pkg::SW_INPUT] = vin_ov_flag;
      end
      else if (cmd_code_in == tvfl_pkg::CMD_STATUS_INPUT)
      begin
        next_rdata = {8'h00, status_input};
      end
      else if (cmd_code_in == tvfl_pkg::CMD_STATUS_TEMP)
      begin
        next_rdata = {8'h00, status_temp};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cmd_rdata_out <= 16'h0000;
    end
    else
    begin
      cmd_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  ot_warn_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    above_ot |=> ot_warn_flag && !alert_n_out)
    else $error("over-temp warning not flagged");
  limit_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_wr_in && cmd_code_in == tvfl_pkg::CMD_OT_WARN |=> ot_warn == $past(cmd_wdata_in))
    else $error("threshold write not stored");
  ut_warn_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    below_ut |=> ut_warn_flag && !alert_n_out)
    else $error("under-temp warning not flagged");
  ut_hysteresis_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ut_cond && !above_ut_warn |=> ut_cond)
    else $error("under-temp fault released inside hysteresis");
  action_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_wr_in && cmd_code_in == tvfl_pkg::CMD_UT_ACTION |=> ut_action == $past(cmd_wdata_in[7:0]))
    else $error("response byte write not stored");
  sticky_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ut_fault_flag && !clear_faults |=> ut_fault_flag)
    else $error("fault bit lost without clear");
  temp_summary_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_rd_in && cmd_code_in == tvfl_pkg::CMD_STATUS_BYTE && temp_any |=> cmd_rdata_out[2])
    else $error("temperature summary bit missing");
  alert_release_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clear_faults && !above_ot && !below_ut && !next_ut_cond && !above_vin |=> alert_n_out)
    else $error("alert not released by clear");
  ut_fault_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) ut_cond ##1 !ut_cond);
  vin_trip_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) vin_ov_flag ##1 !power_enable_out);
  clear_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) !alert_n_out ##1 clear_faults ##1 alert_n_out);
endmodule
`default_nettype wire

// ===== testbench/tvfl_host_model.sv
/*
  Host stand-in for the decoded PMBus command port of the threshold bank.
  Assumes the device samples strobes on the rising edge of clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
module tvfl_host_model (
  // Clock
  input wire logic clk_in,
  // Command port
  output logic [7:0] cmd_code_out,
  output logic cmd_wr_out,
  output logic cmd_rd_out,
  output logic [15:0] cmd_wdata_out,
  input wire logic [15:0] cmd_rdata_in
);
  initial
  begin
    cmd_code_out = 8'h00;
    cmd_wr_out = 1'b0;
    cmd_rd_out = 1'b0;
    cmd_wdata_out = 16'h0000;
  end
  // Idle code and data are inverted so nothing stale looks valid
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk_in);
    cmd_code_out <= code;
    cmd_wdata_out <= data;
    cmd_wr_out <= 1'b1;
    @(negedge clk_in);
    cmd_wr_out <= 1'b0;
    cmd_code_out <= ~code;
    cmd_wdata_out <= ~data;
  endtask
  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    @(negedge clk_in);
    cmd_code_out <= code;
    cmd_rd_out <= 1'b1;
    @(negedge clk_in);
    cmd_rd_out <= 1'b0;
    cmd_code_out <= ~code;
    data = cmd_rdata_in;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tvfl_limits_tb_top.sv
/*
  Self-checking bench for the threshold bank.
  Assumes the host model drives the command port; time unit shortened to 4.
*/
`timescale 1ns/100ps
`default_nettype none
module tvfl_limits_tb_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] temp_in = 16'he8c8;
  logic [15:0] vin_in = 16'he860;
  logic [7:0] code;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic alert_n;
  logic pwr;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  initial
  begin
    forever #50 clk_in = ~clk_in;
  end
  tvfl_limits #(.UT_UNIT_CYCLES(4), .VIN_UNIT_CYCLES(4)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .cmd_code_in(code), .cmd_wr_in(wr), .cmd_rd_in(rd), .cmd_wdata_in(wdata), .cmd_rdata_out(rdata),
    .temp_in(temp_in), .vin_in(vin_in), .alert_n_out(alert_n), .power_enable_out(pwr));
  tvfl_host_model i_host (.clk_in(clk_in), .cmd_code_out(code), .cmd_wr_out(wr), .cmd_rd_out(rd),
    .cmd_wdata_out(wdata), .cmd_rdata_in(rdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic final_report();
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] d;
    i_host.rd(c, d);
    chk($sformatf("reg %h", c), exp, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic do_reset();
    rst_n_in <= 1'b0;
    cyc(6);
    rst_n_in <= 1'b1;
    cyc(1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_resets();
    logic [7:0] c[7] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h60};
    logic [15:0] e[7] = '{16'heb70, 16'he580, 16'he490, 16'h0080, 16'hd3a0, 16'h0080, 16'h0000};
    for (int i = 0; i < 7; i++)
      rchk(c[i], e[i]);
    $display("test resets done");
  endtask
  task automatic t_rw();
    // Fault limit kept below bench temperature so nothing trips
    i_host.wr(8'h53, 16'he4a5);
    i_host.wr(8'h54, 16'hab9c);
    i_host.wr(8'h78, 16'hffff);
    rchk(8'h53, 16'he4a5);
    rchk(8'h54, 16'h009c);
    rchk(8'h78, 16'h0000);
    i_host.wr(8'h53, 16'he490);
    i_host.wr(8'h54, 16'h0080);
    $display("test rw done");
  endtask
  task automatic t_ot_warn();
    temp_in <= 16'heb70;
    cyc(3);
    chk("alert at limit", 1'b1, alert_n);
    temp_in <= 16'hebc0;
    cyc(2);
    chk("alert", 1'b0, alert_n);
    temp_in <= 16'he8c8;
    cyc(3);
    rchk(8'h7d, 16'h0040);
    rchk(8'h78, 16'h0004);
    i_host.wr(8'h03, 16'h0000);
    cyc(1);
    chk("alert cleared", 1'b1, alert_n);
    rchk(8'h7d, 16'h0000);
    $display("test ot_warn done");
  endtask
  task automatic t_vin_ignore();
    i_host.wr(8'h56, 16'h0000);
    vin_in <= 16'he878;
    cyc(6);
    chk("power ignore", 1'b1, pwr);
    rchk(8'h7c, 16'h0080);
    rchk(8'h79, 16'h2001);
    vin_in <= 16'he860;
    i_host.wr(8'h03, 16'h0000);
    $display("test vin_ignore done");
  endtask
  task automatic t_vin_retry();
    int rises = 0;
    logic prev;
    i_host.wr(8'h56, 16'h0089);
    vin_in <= 16'he878;
    cyc(2);
    chk("power disable now", 1'b0, pwr);
    cyc(30);
    chk("power retries used", 1'b0, pwr);
    vin_in <= 16'he860;
    cyc(10);
    chk("power no more retries", 1'b0, pwr);
    i_host.wr(8'h03, 16'h0000);
    cyc(10);
    chk("power retry after clear", 1'b1, pwr);
    i_host.wr(8'h56, 16'h00b9);
    vin_in <= 16'he878;
    prev = pwr;
    for (int i = 0; i < 40; i++)
    begin
      cyc(1);
      if (pwr && !prev)
        rises++;
      prev = pwr;
    end
    chk("restarts while faulted", 1'b1, rises > 2);
    // Back in run before the no-retry byte returns
    vin_in <= 16'he860;
    cyc(10);
    chk("power after fault gone", 1'b1, pwr);
    i_host.wr(8'h56, 16'h0080);
    i_host.wr(8'h03, 16'h0000);
    $display("test vin_retry done");
  endtask
  task automatic t_ut_hold();
    i_host.wr(8'h54, 16'h00c0);
    temp_in <= 16'hee20;
    cyc(5);
    chk("power hold", 1'b0, pwr);
    temp_in <= 16'hee70;
    cyc(6);
    chk("power hysteresis", 1'b0, pwr);
    rchk(8'h7d, 16'h0030);
    temp_in <= 16'he8c8;
    cyc(4);
    chk("power back", 1'b1, pwr);
    i_host.wr(8'h03, 16'h0000);
    $display("test ut_hold done");
  endtask
  task automatic t_ut_delay_off();
    i_host.wr(8'h54, 16'h0041);
    temp_in <= 16'hee20;
    cyc(3);
    chk("power in delay", 1'b1, pwr);
    cyc(10);
    chk("power after delay", 1'b0, pwr);
    temp_in <= 16'he8c8;
    cyc(40);
    chk("power no retry", 1'b0, pwr);
    rchk(8'h78, 16'h0044);
    do_reset();
    chk("power after reset", 1'b1, pwr);
    $display("test ut_delay_off done");
  endtask
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end
  initial
  begin
    do_reset();
    t_resets();
    t_rw();
    t_ot_warn();
    t_vin_ignore();
    t_vin_retry();
    t_ut_hold();
    t_ut_delay_off();
    final_report();
  end
endmodule
`default_nettype wire
